// ### hdl/keypad_display_interface.sv
// Keypad capture, I2C slave, LED/beeper drive and text display feed
// Assumes one 25 MHz clock; pins asynchronous, all but rst_b, maint_fitted and the relay pass-through synchronised here
`timescale 1ns/1ps
`include "kdi_defs.svh"
`default_nettype none
module keypad_display_interface #(
  parameter int BLINK_HALF = `BLINK_HALF_CYC,
  parameter int DCLK_DIV   = `DCLK_DIV
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Keys and option switches
  input  wire logic [7:0] keys,
  input  wire logic       maint_sw,
  input  wire logic       lang_sw,
  input  wire logic       maint_fitted,
  // Host I2C and key interrupt
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            key_irq,
  // Relay-board I2C
  input  wire logic       relay_sda_i,
  output logic            relay_sda_o,
  output logic            relay_sda_oe,
  output logic            relay_scl_o,
  output logic            relay_scl_oe,
  // LEDs and beeper
  output logic            led_sample,
  output logic            led_cal,
  output logic            led_fault,
  output logic            beep,
  output logic            rear_led,
  // Display
  input  wire logic       supply_low,
  output logic            disp_clk,
  output logic [7:0]      disp_data,
  output logic [6:0]      disp_addr,
  output logic            disp_pwr_en,
  output logic            disp_rst
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (BLINK_HALF < 2 || BLINK_HALF > 16777215) begin : g_chk_blink
    $error("BLINK_HALF out of range");
  end
  if (DCLK_DIV < 3 || DCLK_DIV > 255) begin : g_chk_dclk
    $error("DCLK_DIV out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0][7:0]            key_s;
    logic [7:0]                 key_f;
    logic [7:0]                 key_last;
    logic [7:0]                 key_word;
    logic                       key_flag;
    logic [2:0][1:0]            sw_s;
    logic [1:0]                 sw_f;
    logic                       sw_chg;
    logic [2:0]                 scl_s;
    logic [2:0]                 sda_s;
    logic [2:0]                 rsda_s;
    logic [2:0]                 low_s;
    logic                       scl_f;
    logic                       sda_f;
    logic                       rsda_f;
    logic                       low_f;
    logic                       relay_up;
    kdi_pkg::i2c_st_e           st;
    logic [2:0]                 bitc;
    logic [7:0]                 sh;
    logic                       is_disp;
    logic                       rw;
    logic                       bidx;
    logic                       oe;
    logic                       acked;
    logic [7:0]                 led_ctl;
    logic [7:0]                 dsp_ctl;
    logic [`TEXT_LEN-1:0][7:0]  mem;
    logic [6:0]                 cur;
    logic [6:0]                 rd_ptr;
    logic [6:0]                 paddr;
    logic [7:0]                 pdata;
    logic [23:0]                blink_cnt;
    logic                       blink;
    logic [7:0]                 dclk_cnt;
    logic                       dclk;
    logic [15:0]                bo_cnt;
    logic [4:0]                 leds;
    logic                       pwr;
    logic                       drst;
  } state_s;

  state_s q;
  state_s n;
  logic   scl_nf;
  logic   sda_nf;
  logic   rsda_nf;
  logic   rise;
  logic   fall;
  logic   key_clr;
  logic   sw_clr;
  logic [7:0] rbyte;
  logic [7:0] key_nf;
  logic [1:0] sw_nf;

  // Glitch filter: accept once second and third stages agree
  function automatic logic filt(input logic [2:0] s, input logic f);
    return (s[1] == s[2]) ? s[2] : f;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    n = q;
    key_clr = 1'b0;
    sw_clr = 1'b0;
    // Synchronisers, stage 0 feeds only stage 1
    n.key_s = {q.key_s[1:0], keys};
    n.sw_s = {q.sw_s[1:0], {lang_sw, maint_sw}};
    n.scl_s = {q.scl_s[1:0], scl_i};
    n.sda_s = {q.sda_s[1:0], sda_i};
    n.rsda_s = {q.rsda_s[1:0], relay_sda_i};
    n.low_s = {q.low_s[1:0], supply_low};
    key_nf = (q.key_s[1] == q.key_s[2]) ? q.key_s[2] : q.key_f;
    sw_nf = (q.sw_s[1] == q.sw_s[2]) ? q.sw_s[2] : q.sw_f;
    scl_nf = filt(q.scl_s, q.scl_f);
    sda_nf = filt(q.sda_s, q.sda_f);
    rsda_nf = filt(q.rsda_s, q.rsda_f);
    n.key_f = key_nf;
    n.sw_f = sw_nf;
    n.scl_f = scl_nf;
    n.sda_f = sda_nf;
    n.rsda_f = rsda_nf;
    n.low_f = filt(q.low_s, q.low_f);
    rise = scl_nf & ~q.scl_f;
    fall = ~scl_nf & q.scl_f;
    rbyte = q.bidx ? {q.key_flag, q.sw_chg, 4'h0, q.sw_f} : q.key_word;

    // Host is sole master: we only follow its clock
    if (q.scl_f && scl_nf && q.sda_f && !sda_nf) begin
      n.st = kdi_pkg::I_ADDR;
      n.bitc = 3'd0;
      n.oe = 1'b0;
    end else if (q.scl_f && scl_nf && !q.sda_f && sda_nf) begin
      n.st = kdi_pkg::I_IDLE;
      n.oe = 1'b0;
    end else begin
      case (q.st)
        kdi_pkg::I_ADDR: if (rise) begin
          n.sh = {q.sh[6:0], sda_nf};
          n.bitc = 3'(q.bitc + 3'd1);
          if (q.bitc == 3'd7) begin
            n.is_disp = (q.sh[6:0] == `DISP_ADDR);
            n.rw = sda_nf;
            n.bidx = 1'b0;
            // Relay addresses never match: no ack, no decode
            if (q.sh[6:0] == `EXP_ADDR || q.sh[6:0] == `DISP_ADDR) begin
              n.st = kdi_pkg::I_ACK_A;
            end else begin
              n.st = kdi_pkg::I_IDLE;
            end
          end
        end
        kdi_pkg::I_ACK_A: if (fall) begin
          if (!q.oe) begin
            n.oe = 1'b1;
          end else if (q.rw && !q.is_disp) begin
            n.st = kdi_pkg::I_RDATA;
            n.sh = rbyte;
            n.oe = ~rbyte[7];
            n.bitc = 3'd0;
          end else begin
            n.st = q.rw ? kdi_pkg::I_IDLE : kdi_pkg::I_WDATA;
            n.oe = 1'b0;
            n.bitc = 3'd0;
          end
        end
        kdi_pkg::I_WDATA: if (rise) begin
          n.sh = {q.sh[6:0], sda_nf};
          n.bitc = 3'(q.bitc + 3'd1);
          if (q.bitc == 3'd7) begin
            n.st = kdi_pkg::I_ACK_W;
            if (q.is_disp) begin
              // Text stream into the 2 x 40 image
              case ({q.sh[6:0], sda_nf})
                `TTY_FF: n.cur = 7'd0;
                `TTY_CR: n.cur = (q.cur >= 7'(`LINE_LEN)) ? 7'(`LINE_LEN) : 7'd0;
                `TTY_LF: n.cur = (q.cur >= 7'(`LINE_LEN)) ?
                                 7'(q.cur - 7'(`LINE_LEN)) : 7'(q.cur + 7'(`LINE_LEN));
                default: begin
                  n.mem[q.cur] = {q.sh[6:0], sda_nf};
                  n.cur = (q.cur == 7'(`TEXT_LEN - 1)) ? 7'd0 : 7'(q.cur + 7'd1);
                end
              endcase
            end else if (!q.bidx) begin
              n.led_ctl = {q.sh[6:0], sda_nf};
              n.bidx = 1'b1;
            end else begin
              n.dsp_ctl = {q.sh[6:0], sda_nf};
            end
          end
        end
        kdi_pkg::I_ACK_W: if (fall) begin
          if (!q.oe) begin
            n.oe = 1'b1;
          end else begin
            n.oe = 1'b0;
            n.st = kdi_pkg::I_WDATA;
            n.bitc = 3'd0;
          end
        end
        kdi_pkg::I_RDATA: begin
          if (rise) begin
            n.bitc = 3'(q.bitc + 3'd1);
            if (q.bitc == 3'd7) begin
              n.st = kdi_pkg::I_ACK_R;
              n.bitc = 3'd0;
            end
          end else if (fall) begin
            n.oe = ~q.sh[6];
            n.sh = {q.sh[6:0], 1'b0};
          end
        end
        kdi_pkg::I_ACK_R: begin
          if (fall && q.bitc == 3'd0) begin
            n.oe = 1'b0;
          end else if (rise && q.bitc == 3'd0) begin
            // Either ack or nack ends the read of this byte
            n.acked = ~sda_nf;
            n.bitc = 3'd1;
            key_clr = ~q.bidx;
            sw_clr = q.bidx;
            n.bidx = 1'b1;
          end else if (fall) begin
            n.bitc = 3'd0;
            n.st = q.acked ? kdi_pkg::I_RDATA : kdi_pkg::I_IDLE;
            n.sh = rbyte;
            n.oe = q.acked & ~rbyte[7];
          end
        end
        default: n.st = kdi_pkg::I_IDLE;
      endcase
    end

    // Key capture; flag clear first so a new capture wins
    if (key_clr) begin
      n.key_flag = 1'b0;
    end
    if (!q.key_flag && q.key_f != q.key_last) begin
      n.key_word = q.key_f;
      n.key_last = q.key_f;
      n.key_flag = 1'b1;
    end
    // Switch change: set beats clear
    if (sw_clr) begin
      n.sw_chg = 1'b0;
    end
    if (sw_nf != q.sw_f) begin
      n.sw_chg = 1'b1;
    end

    // Relay upstream drive, held so the repeater cannot latch
    if (rsda_nf) begin
      n.relay_up = 1'b0;
    end else if (sda_nf && !q.oe) begin
      n.relay_up = 1'b1;
    end

    // Blink divider, about 1 Hz
    if (q.blink_cnt == 24'(BLINK_HALF - 1)) begin
      n.blink_cnt = 24'd0;
      n.blink = ~q.blink;
    end else begin
      n.blink_cnt = 24'(q.blink_cnt + 24'd1);
    end

    // Display clock; new data on falling edge, display takes rising
    if (q.dclk_cnt == 8'(DCLK_DIV - 1)) begin
      n.dclk_cnt = 8'd0;
      n.dclk = ~q.dclk;
      if (q.dclk) begin
        n.pdata = q.mem[q.rd_ptr];
        n.paddr = q.rd_ptr;
        n.rd_ptr = (q.rd_ptr == 7'(`TEXT_LEN - 1)) ? 7'd0 : 7'(q.rd_ptr + 7'd1);
      end
    end else begin
      n.dclk_cnt = 8'(q.dclk_cnt + 8'd1);
    end

    // Brownout: off while low and a while after, then a reset pulse
    if (q.low_f) begin
      n.bo_cnt = 16'(`BO_OFF_CYC + `BO_RST_CYC);
    end else if (q.bo_cnt != 16'd0) begin
      n.bo_cnt = 16'(q.bo_cnt - 16'd1);
    end
    n.pwr = ~q.dsp_ctl[`DC_OFF] & (q.bo_cnt <= 16'(`BO_RST_CYC)) & ~q.low_f;
    n.drst = q.dsp_ctl[`DC_RST] | (q.bo_cnt != 16'd0);

    // LED decode
    n.leds[0] = q.led_ctl[`LC_SAMPLE] &
                (q.led_ctl[`LC_HOLD] ? q.blink : q.led_ctl[`LC_STORE]);
    n.leds[1] = q.led_ctl[`LC_CALMODE] ? q.blink : q.led_ctl[`LC_AUTOCAL];
    n.leds[2] = q.led_ctl[`LC_WARN] & q.blink;
    n.leds[3] = q.led_ctl[`LC_BEEP];
    n.leds[4] = maint_fitted & q.dsp_ctl[`DC_MAINT];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      // Bus lines idle high; zeros here would show a false edge on release
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.rsda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.rsda_f <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs; relay pass-through is combinational, relay SDA gated by our own drive, no decode
  assign sda_o = 1'b0;
  assign sda_oe = q.oe | q.relay_up;
  assign key_irq = q.key_flag | q.sw_chg;
  assign relay_sda_o = 1'b0;
  assign relay_sda_oe = ~sda_i & ~q.relay_up & ~q.oe;
  assign relay_scl_o = 1'b0;
  assign relay_scl_oe = ~scl_i;
  assign led_sample = q.leds[0];
  assign led_cal = q.leds[1];
  assign led_fault = q.leds[2];
  assign beep = q.leds[3];
  assign rear_led = q.leds[4];
  assign disp_clk = q.dclk;
  assign disp_data = q.pdata;
  assign disp_addr = q.paddr;
  assign disp_pwr_en = q.pwr;
  assign disp_rst = q.drst;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_key_capture: assert property (
    (!q.key_flag && q.key_f != q.key_last) |=> q.key_flag && q.key_word == $past(q.key_f))
    else $error("key word not captured");
  a_key_hold: assert property (
    (q.key_flag && !key_clr) |=> $stable(q.key_word) && q.key_flag)
    else $error("key word changed while pending");
  a_irq_follow: assert property (
    $rose(q.key_flag) |-> key_irq)
    else $error("interrupt not raised with key flag");
  a_key_clear: assert property (
    (key_clr && q.key_f == q.key_last) |=> !q.key_flag)
    else $error("key flag not cleared");
  a_no_repeat: assert property (
    (!q.key_flag && q.key_f == q.key_last && !key_clr) |=> !q.key_flag)
    else $error("repeat key event");
  a_sw_report: assert property (
    (sw_nf != q.sw_f) |=> q.sw_chg && key_irq)
    else $error("switch change not reported");
  a_beep_cmd: assert property (
    q.led_ctl[`LC_BEEP] |=> beep)
    else $error("beeper not following command");
  a_dclk_high: assert property (
    $rose(disp_clk) |-> (disp_clk && $stable(disp_data)) [*3])
    else $error("display clock too short");
  a_brown_off: assert property (
    q.low_f |=> ##1 (!disp_pwr_en && disp_rst))
    else $error("display not blanked on brownout");
  a_fault_off: assert property (
    !q.led_ctl[`LC_WARN] |=> !led_fault)
    else $error("fault LED lit without warning");
  a_maint_led: assert property (
    (maint_fitted && q.dsp_ctl[`DC_MAINT]) |=> rear_led)
    else $error("rear LED not lit");
  a_relay_noack: assert property (
    (q.st == kdi_pkg::I_ADDR && rise && q.bitc == 3'd7 &&
     q.sh[6:0] != `EXP_ADDR && q.sh[6:0] != `DISP_ADDR) |=> q.st == kdi_pkg::I_IDLE && !q.oe)
    else $error("relay address decoded");

  c_key_read: cover property ($fell(q.key_flag));
  c_disp_write: cover property (q.st == kdi_pkg::I_ACK_W && q.is_disp);
  c_brownout: cover property ($fell(disp_rst) && disp_pwr_en);

endmodule
`default_nettype wire

// ### hdl/kdi_defs.svh
// Constants for the front-panel keypad and display interface
// Assumes inclusion by the design file; definitions only
// Operation
// - Capture all eight keys on change
// - Set key flag, serialize word to host
// - Key flag drives the host interrupt
// - Key interrupt on dedicated line, rest I2C
// - Host read acknowledgement clears key flag
// - No repeat while key held
// - Host commands LEDs and beeper
// - Report option switch changes
// - Serial text to parallel display image
// - Shared display clock keeps transfer synchronized
// - Host can blank and reset display
// - Rear LED lit in maintenance mode
// - Supply dip blanks then resets display
// - Relay traffic passes through untouched
// - Green LED follows sample and logging
// - Yellow LED follows calibration state
// - Red LED blinks on warnings, else off
// - Display holds two lines of 40
// - Exactly eight independent key inputs
// - Separate interrupt line to host
`ifndef KDI_DEFS_SVH
`define KDI_DEFS_SVH
`define MCLK_HZ 25000000
`define EXP_ADDR 7'h20
`define DISP_ADDR 7'h21
// Control byte 0: LEDs and beeper
`define LC_SAMPLE 0
`define LC_STORE 1
`define LC_HOLD 2
`define LC_AUTOCAL 3
`define LC_CALMODE 4
`define LC_WARN 5
`define LC_BEEP 6
// Control byte 1: display
`define DC_OFF 0
`define DC_RST 1
`define DC_MAINT 2
`define BLINK_HZ 1
`define BLINK_HALF_CYC (`MCLK_HZ / (2 * `BLINK_HZ))
`define DCLK_HZ 250000
`define DCLK_DIV (`MCLK_HZ / (2 * `DCLK_HZ))
`define BO_OFF_US 10
`define BO_OFF_CYC ((`BO_OFF_US * `MCLK_HZ + 999999) / 1000000)
`define BO_RST_US 5
`define BO_RST_CYC ((`BO_RST_US * `MCLK_HZ + 999999) / 1000000)
`define TTY_LF 8'h0a
`define TTY_FF 8'h0c
`define TTY_CR 8'h0d
`define LINE_LEN 40
`define TEXT_LEN 80
`endif

// ### hdl/kdi_pkg.sv
// Types shared by the keypad and display interface
// Assumes nothing beyond a SystemVerilog compiler
package kdi_pkg;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_WDATA, I_ACK_W, I_RDATA, I_ACK_R
  } i2c_st_e;
endpackage

// ### bench/i2c_host_model.sv
// I2C host model: the only bus master, owns SCL and addresses targets
// Assumes the bench resolves SDA as a pulled-up open-drain wire
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter int HALF = 160
) (
  // Bus pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ------------------------------
  // Idle bus and frame primitives
  // ------------------------------
  // Clock parked high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Every change lands on an mclk falling edge, clear of sampling
  task automatic start();
    #40 sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // Data moves mid low phase; read late in high phase, well after the answer
  task automatic bit_io(input logic b, output logic r);
    #(HALF / 2) sda_low = ~b;
    #(HALF / 2) scl = 1'b1;
    #(HALF - 40) r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], nak);
    end
    bit_io(1'b1, nak);
  endtask
  // Closing ack or nack tells the device the byte was taken
  task automatic rx(output logic [7:0] d, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nak, r);
  endtask
  task automatic stop();
    #(HALF / 2) sda_low = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_keypad_display_interface.sv
// Bench: host frames, key and switch events, LED modes, display feed
// Assumes the host model file and a pulled-up open-drain SDA wire
`timescale 1ns/1ps
`include "kdi_defs.svh"
`default_nettype none
module tb_keypad_display_interface;
  // ------------------------------
  // Setup and pins
  // ------------------------------
  localparam int DIV   = 3;
  localparam int BLINK = 8;
  // Packed as ctl byte, LED index, mode (0 off, 1 on, 2 blink)
  localparam logic [11:0] LTAB [11] = '{12'h000, 12'h010, 12'h031, 12'h052,
    12'h085, 12'h186, 12'h004, 12'h20a, 12'h008, 12'h40d, 12'h00c};
  localparam logic [7:0] TXT [7] = '{8'h0c, 8'h41, 8'h42, 8'h0a, 8'h43, 8'h0d, 8'h44};
  logic       mclk, rst_b, maint_sw, lang_sw, maint_fitted, supply_low;
  logic [7:0] keys, disp_data;
  logic [6:0] disp_addr;
  logic       sda_oe, key_irq, relay_sda_oe, relay_scl_oe, scl, host_low;
  logic       led_sample, led_cal, led_fault, beep, rear_led;
  logic       disp_clk, disp_pwr_en, disp_rst;
  int         miscompares, total_checks;
  wire  logic sda       = ~(host_low | sda_oe);
  wire  logic relay_sda = ~relay_sda_oe;
  wire  logic [3:0] leds = {beep, led_fault, led_cal, led_sample};

  always #20 mclk = ~mclk;

  keypad_display_interface #(.BLINK_HALF(BLINK), .DCLK_DIV(DIV)) u_keypad_display_interface (
    .mclk(mclk), .rst_b(rst_b), .keys(keys), .maint_sw(maint_sw), .lang_sw(lang_sw),
    .maint_fitted(maint_fitted), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .key_irq(key_irq), .relay_sda_i(relay_sda), .relay_sda_o(), .relay_sda_oe(relay_sda_oe),
    .relay_scl_o(), .relay_scl_oe(relay_scl_oe), .led_sample(led_sample), .led_cal(led_cal),
    .led_fault(led_fault), .beep(beep), .rear_led(rear_led), .supply_low(supply_low),
    .disp_clk(disp_clk), .disp_data(disp_data), .disp_addr(disp_addr),
    .disp_pwr_en(disp_pwr_en), .disp_rst(disp_rst));

  i2c_host_model u_i2c_host_model (.scl(scl), .sda_low(host_low), .sda(sda));

  task automatic final_report();
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One frame to address a, one or two data bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1,
                    input int n, output logic nak);
    logic r;
    u_i2c_host_model.start();
    u_i2c_host_model.tx({a, 1'b0}, nak);
    u_i2c_host_model.tx(b0, r);
    nak |= r;
    if (n > 1) begin
      u_i2c_host_model.tx(b1, r);
      nak |= r;
    end
    u_i2c_host_model.stop();
  endtask

  task automatic rd(input int n, output logic [7:0] d0, output logic [7:0] d1);
    logic r;
    u_i2c_host_model.start();
    u_i2c_host_model.tx({`EXP_ADDR, 1'b1}, r);
    u_i2c_host_model.rx(d0, n == 1);
    if (n > 1) begin
      u_i2c_host_model.rx(d1, 1'b1);
    end
    u_i2c_host_model.stop();
  endtask

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (key_irq !== v && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      final_report();
    end
  endtask

  // Toggle count over five blink halves tells off, on and blinking apart
  task automatic led_mode(input logic [11:0] e);
    logic p;
    int   t;
    t = 0;
    p = leds[e[3:2]];
    repeat (5 * BLINK) begin
      @(negedge mclk);
      t += (leds[e[3:2]] !== p);
      p = leds[e[3:2]];
    end
    chk((t >= 3) ? 8'h02 : (t == 0) ? {7'h00, p} : 8'h03, {6'h00, e[1:0]});
  endtask

  function automatic logic [7:0] img(input logic [6:0] a);
    case (a)
      7'h00:   return 8'h41;
      7'h01:   return 8'h42;
      7'h28:   return 8'h44;
      7'h2a:   return 8'h43;
      default: return 8'h00;
    endcase
  endfunction

  // Watchdog so a stuck wait cannot hang the run
  initial begin
    #2000000;
    miscompares++;
    final_report();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic [7:0] d0, d1;
    logic       nak;
    int         n, pa;
    mclk = 1'b0;
    rst_b = 1'b0;
    keys = 8'h00;
    maint_sw = 1'b0;
    lang_sw = 1'b0;
    maint_fitted = 1'b1;
    supply_low = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    chk({5'h00, disp_rst, disp_pwr_en, key_irq}, 8'h02);
    chk({4'h0, leds}, 8'h00);
    // Every LED and beeper mode in turn
    foreach (LTAB[i]) begin
      wr(`EXP_ADDR, LTAB[i][11:4], 8'h00, 1, nak);
      chk({7'h00, nak}, 8'h00);
      led_mode(LTAB[i]);
    end
    // Foreign address: no ack, no effect, pins passed through idle
    wr(7'h50, 8'h7f, 8'h7f, 2, nak);
    chk({7'h00, nak}, 8'h01);
    led_mode(12'h00c);
    chk({6'h00, relay_scl_oe, relay_sda_oe}, 8'h00);
    // Key word held while flagged, recaptured after the read
    @(negedge mclk);
    keys = 8'h05;
    wait_irq(1'b1);
    keys = 8'h07;
    rd(1, d0, d1);
    chk(d0, 8'h05);
    wait_irq(1'b1);
    rd(1, d0, d1);
    chk(d0, 8'h07);
    wait_irq(1'b0);
    n = 0;
    repeat (100) begin
      @(negedge mclk);
      n += (key_irq !== 1'b0);
    end
    chk(n[7:0], 8'h00);
    keys = 8'h00;
    wait_irq(1'b1);
    rd(1, d0, d1);
    chk(d0, 8'h00);
    wait_irq(1'b0);
    // Option switches reported in the status byte
    @(negedge mclk);
    maint_sw = 1'b1;
    lang_sw = 1'b1;
    wait_irq(1'b1);
    rd(2, d0, d1);
    chk(d1, 8'h43);
    wait_irq(1'b0);
    // Rear LED, then display off and reset in all pairings
    wr(`EXP_ADDR, 8'h00, 8'h04, 2, nak);
    chk({7'h00, rear_led}, 8'h01);
    // Option not fitted: rear LED stays dark despite maintenance mode
    @(negedge mclk);
    maint_fitted = 1'b0;
    repeat (2) @(negedge mclk);
    chk({7'h00, rear_led}, 8'h00);
    maint_fitted = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      wr(`EXP_ADDR, 8'h00, 8'(i), 2, nak);
      chk({5'h00, rear_led, disp_rst, disp_pwr_en}, {6'h00, i[1], ~i[0]});
    end
    // Text with form feed, line feed and carriage return
    foreach (TXT[i]) begin
      wr(`DISP_ADDR, TXT[i], 8'h00, 1, nak);
    end
    // Scan: one position per display clock, whole image compared
    pa = -1;
    n = 0;
    repeat (700) begin
      d1 = {7'h00, disp_clk};
      @(negedge mclk);
      n++;
      if (disp_clk === 1'b1 && d1 === 8'h00) begin
        if (pa >= 0) begin
          chk(n[7:0], 8'(2 * DIV));
          chk({1'b0, disp_addr}, (pa == 79) ? 8'h00 : 8'(pa + 1));
        end
        chk(disp_data, img(disp_addr));
        pa = int'(disp_addr);
        n = 0;
      end
    end
    // Supply dip: display dark, then powered with reset, then released
    @(negedge mclk);
    supply_low = 1'b1;
    repeat (6) @(negedge mclk);
    chk({6'h00, disp_rst, disp_pwr_en}, 8'h02);
    supply_low = 1'b0;
    n = 0;
    while (disp_pwr_en !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, n >= `BO_OFF_CYC && n <= `BO_OFF_CYC + 6}, 8'h01);
    n = 0;
    while (disp_rst === 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, n >= `BO_RST_CYC - 2 && n <= `BO_RST_CYC + 3}, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
